// file: hdl/lbc_pkg.sv
// Package: offsets, reset values, field positions, timing and types of the lane B bank
package lbc_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFS_B1_DEEMPH   = 8'h18;
	localparam logic [7:0] OFS_B1_SDTH     = 8'h19;
	localparam logic [7:0] OFS_RSV_1A      = 8'h1A;
	localparam logic [7:0] OFS_RSV_1B      = 8'h1B;
	localparam logic [7:0] OFS_B2_DETECT   = 8'h1C;
	localparam logic [7:0] OFS_B2_EQ       = 8'h1D;
	localparam logic [7:0] OFS_B2_SWING    = 8'h1E;
	localparam logic [7:0] OFS_B2_DEEMPH   = 8'h1F;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_DEEMPH      = 8'h02;
	localparam logic [7:0] RST_SDTH        = 8'h00;
	localparam logic [7:0] RST_RSV         = 8'h00;
	localparam logic [7:0] RST_DETECT      = 8'h00;
	localparam logic [7:0] RST_EQ          = 8'h2F;
	localparam logic [7:0] RST_SWING       = 8'hAD;

	// ==========================================================
	// Field positions
	localparam int DEEMPH_LSB      = 0;
	localparam int STATUS_BIT      = 7;
	localparam int SD_ASSERT_LSB   = 2;
	localparam int SD_DEASSERT_LSB = 0;
	localparam int DET_MODE_LSB    = 2;
	localparam int SCP_BIT         = 7;
	localparam int SWING_LSB       = 0;

	// ==========================================================
	// Detect mode codes
	localparam logic [1:0] DET_FORCE_HIZ  = 2'h0;
	localparam logic [1:0] DET_AUTO_LIMIT = 2'h1;
	localparam logic [1:0] DET_AUTO_EVER  = 2'h2;
	localparam logic [1:0] DET_FORCE_TERM = 2'h3;

	// ==========================================================
	// Timing
	localparam int CLK_HZ            = 50_000_000;
	localparam int DETECT_PERIOD_MS  = 12;
	localparam int DETECT_WINDOW_MS  = 600;
	localparam int DETECT_PERIOD_CYC = DETECT_PERIOD_MS * (CLK_HZ / 1000);
	localparam int DETECT_ATTEMPTS   = DETECT_WINDOW_MS / DETECT_PERIOD_MS;
	localparam int PROBE_SETTLE_CYC  = 4;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {DET_OFF, DET_WAIT, DET_PROBE, DET_FOUND, DET_GIVEUP} lbc_det_e;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} lbc_reg_req_s;

	typedef struct packed {
		logic [2:0] b1_deemph;
		logic [1:0] b1_sd_assert;
		logic [1:0] b1_sd_deassert;
		logic [2:0] b2_deemph;
		logic [7:0] b2_eq;
		logic [2:0] b2_swing;
		logic       b2_short_protect;
		logic       b2_terminated;
		logic       b2_probe;
	} lbc_lane_ctrl_s;

	typedef struct packed {
		logic [2:0]  b1_deemph;
		logic [7:0]  b1_sdth;
		logic [7:0]  rsv_1a;
		logic [7:0]  rsv_1b;
		logic [7:0]  b2_det;
		logic [7:0]  b2_eq;
		logic [7:0]  b2_swing;
		logic [2:0]  b2_deemph;
		lbc_det_e    det;
		logic [23:0] period_cnt;
		logic [5:0]  attempts;
		logic [2:0]  settle_cnt;
		logic        term;
		logic        probe;
		logic [1:0]  mode_last;
		logic [5:0]  pin_s1;
		logic [5:0]  pin_s2;
		logic        far_s1;
		logic        far_s2;
		logic [7:0]  rdata;
	} lbc_state_s;

endpackage

// file: hdl/lbc_lane_b_config.sv
// Lane B configuration register bank with far-end receiver detect sequencer
// ==========================================================
// Notes on behaviour
// - De-emphasis codes 0..7 select 0,-1.5,-3.5,-5,-6,-8,-9,-12 dB.
// - De-emphasis field resets to code 2 (-3.5 dB), not to 0 dB.
// - Assert threshold bits 3:2 pick 50/40/75/58 mVp-p, default 00.
// - De-assert threshold bits 1:0 pick 37/22/55/45 mVp-p, default 00.
// - Threshold fields act only with global override bit 6; else pins govern.
// - Detect mode 00 forces high impedance, 11 forces 50 ohm termination.
// - Mode 01 probes every 12 ms, 50 attempts, then stops if nothing found.
// - Mode 10 probes every 12 ms forever until a receiver is found.
// - Auto modes keep high impedance until detection, then terminate 50 ohm.
// - Detect mode field acts only with global override bit 3; else pin governs.
// - Equalization is a full byte resetting to 0x2F, four boost levels.
// - Swing register bit 7 enables short-circuit protection when set.
// - Swing ratio bits 2:0 select 0.57..1.04, default code 101.
// - De-emphasis bit 7 reads detect status: 1 terminated, 0 high impedance.
`timescale 1ns/1ps
`default_nettype none

module lbc_lane_b_config #(
	parameter int unsigned DETECT_PERIOD_CYC = lbc_pkg::DETECT_PERIOD_CYC,
	parameter int unsigned DETECT_ATTEMPTS   = lbc_pkg::DETECT_ATTEMPTS
) (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    reset_n,
	// Management host register port
	input  wire lbc_pkg::lbc_reg_req_s   host_req,
	output logic [7:0]                   host_rdata,
	// Configuration EEPROM load port
	input  wire lbc_pkg::lbc_reg_req_s   eeprom_req,
	// Global override bits from register 0x08
	input  wire logic                    global_sd_override,
	input  wire logic                    global_detect_override,
	// Pin straps and analog sense, asynchronous
	input  wire logic [3:0]              sd_threshold_pin,
	input  wire logic [1:0]              detect_mode_pin,
	input  wire logic                    far_end_sense,
	// Detect status of lane B one, same clock
	input  wire logic                    lane_b1_terminated,
	// Analog lane controls
	output lbc_pkg::lbc_lane_ctrl_s      lane_ctrl
);

	lbc_pkg::lbc_state_s   s_reg;
	lbc_pkg::lbc_state_s   s_next;
	lbc_pkg::lbc_reg_req_s req;
	logic [1:0]            mode;

	// ==========================================================
	// Next state
	always_comb
	begin
		s_next = s_reg;
		s_next.probe = 1'b0;
		// Syncs: first stage is only copied onward
		s_next.pin_s1 = {detect_mode_pin, sd_threshold_pin};
		s_next.pin_s2 = s_reg.pin_s1;
		s_next.far_s1 = far_end_sense;
		s_next.far_s2 = s_reg.far_s1;

		// EEPROM wins a same-cycle clash; it only runs during power-up load
		req = eeprom_req.wr ? eeprom_req : host_req;
		if (req.wr)
		begin
			if (req.addr == lbc_pkg::OFS_B1_DEEMPH)
				s_next.b1_deemph = req.data[2:0];
			else if (req.addr == lbc_pkg::OFS_B1_SDTH)
				s_next.b1_sdth = req.data;
			else if (req.addr == lbc_pkg::OFS_RSV_1A)
				s_next.rsv_1a = req.data;
			else if (req.addr == lbc_pkg::OFS_RSV_1B)
				s_next.rsv_1b = req.data;
			else if (req.addr == lbc_pkg::OFS_B2_DETECT)
				s_next.b2_det = req.data;
			else if (req.addr == lbc_pkg::OFS_B2_EQ)
				s_next.b2_eq = req.data;
			else if (req.addr == lbc_pkg::OFS_B2_SWING)
				s_next.b2_swing = req.data;
			else if (req.addr == lbc_pkg::OFS_B2_DEEMPH)
				s_next.b2_deemph = req.data[2:0];
		end

		// Detect mode source
		mode = global_detect_override ? s_reg.b2_det[lbc_pkg::DET_MODE_LSB +: 2]
			: s_reg.pin_s2[5:4];
		s_next.mode_last = mode;

		// Any mode change restarts the sequence from scratch
		if (mode != s_reg.mode_last)
		begin
			s_next.period_cnt = 24'h000000;
			s_next.attempts   = 6'h00;
			s_next.settle_cnt = 3'h0;
			s_next.term       = (mode == lbc_pkg::DET_FORCE_TERM);
			if (mode == lbc_pkg::DET_AUTO_LIMIT || mode == lbc_pkg::DET_AUTO_EVER)
				s_next.det = lbc_pkg::DET_WAIT;
			else
				s_next.det = lbc_pkg::DET_OFF;
		end
		else
		begin
			case (s_reg.det)
				lbc_pkg::DET_OFF:
				begin
					s_next.term = (mode == lbc_pkg::DET_FORCE_TERM);
				end
				lbc_pkg::DET_WAIT:
				begin
					s_next.term = 1'b0;
					if (s_reg.period_cnt == 24'(DETECT_PERIOD_CYC - 1))
					begin
						s_next.period_cnt = 24'h000000;
						s_next.probe      = 1'b1;
						s_next.attempts   = s_reg.attempts + 6'h01;
						s_next.settle_cnt = 3'h0;
						s_next.det        = lbc_pkg::DET_PROBE;
					end
					else
						s_next.period_cnt = s_reg.period_cnt + 24'h000001;
				end
				lbc_pkg::DET_PROBE:
				begin
					// Period keeps running so probes stay exactly one period apart
					s_next.period_cnt = s_reg.period_cnt + 24'h000001;
					s_next.settle_cnt = s_reg.settle_cnt + 3'h1;
					if (s_reg.settle_cnt == 3'(lbc_pkg::PROBE_SETTLE_CYC - 1))
					begin
						if (s_reg.far_s2)
						begin
							s_next.det  = lbc_pkg::DET_FOUND;
							s_next.term = 1'b1;
						end
						else if (mode == lbc_pkg::DET_AUTO_LIMIT
							&& s_reg.attempts == 6'(DETECT_ATTEMPTS))
							s_next.det = lbc_pkg::DET_GIVEUP;
						else
							s_next.det = lbc_pkg::DET_WAIT;
					end
				end
				lbc_pkg::DET_FOUND:
				begin
					s_next.term = 1'b1;
				end
				default:
				begin
					s_next.term = 1'b0;
				end
			endcase
		end

		// Read data, registered; unmapped offsets read zero
		if (host_req.addr == lbc_pkg::OFS_B1_DEEMPH)
			s_next.rdata = {lane_b1_terminated, 4'h0, s_reg.b1_deemph};
		else if (host_req.addr == lbc_pkg::OFS_B1_SDTH)
			s_next.rdata = s_reg.b1_sdth;
		else if (host_req.addr == lbc_pkg::OFS_RSV_1A)
			s_next.rdata = s_reg.rsv_1a;
		else if (host_req.addr == lbc_pkg::OFS_RSV_1B)
			s_next.rdata = s_reg.rsv_1b;
		else if (host_req.addr == lbc_pkg::OFS_B2_DETECT)
			s_next.rdata = s_reg.b2_det;
		else if (host_req.addr == lbc_pkg::OFS_B2_EQ)
			s_next.rdata = s_reg.b2_eq;
		else if (host_req.addr == lbc_pkg::OFS_B2_SWING)
			s_next.rdata = s_reg.b2_swing;
		else if (host_req.addr == lbc_pkg::OFS_B2_DEEMPH)
			s_next.rdata = {s_reg.term, 4'h0, s_reg.b2_deemph};
		else
			s_next.rdata = 8'h00;
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			s_reg            <= '0;
			s_reg.b1_deemph  <= lbc_pkg::RST_DEEMPH[2:0];
			s_reg.b1_sdth    <= lbc_pkg::RST_SDTH;
			s_reg.rsv_1a     <= lbc_pkg::RST_RSV;
			s_reg.rsv_1b     <= lbc_pkg::RST_RSV;
			s_reg.b2_det     <= lbc_pkg::RST_DETECT;
			s_reg.b2_eq      <= lbc_pkg::RST_EQ;
			s_reg.b2_swing   <= lbc_pkg::RST_SWING;
			s_reg.b2_deemph  <= lbc_pkg::RST_DEEMPH[2:0];
			s_reg.det        <= lbc_pkg::DET_OFF;
			s_reg.mode_last  <= lbc_pkg::DET_FORCE_HIZ;
		end
		else
			s_reg <= s_next;
	end

	// ==========================================================
	// Outputs
	always_comb
	begin
		lane_ctrl.b1_deemph        = s_reg.b1_deemph;
		// Pin code is used unless software has taken the thresholds over
		lane_ctrl.b1_sd_assert     = global_sd_override
			? s_reg.b1_sdth[lbc_pkg::SD_ASSERT_LSB +: 2] : s_reg.pin_s2[3:2];
		lane_ctrl.b1_sd_deassert   = global_sd_override
			? s_reg.b1_sdth[lbc_pkg::SD_DEASSERT_LSB +: 2] : s_reg.pin_s2[1:0];
		lane_ctrl.b2_deemph        = s_reg.b2_deemph;
		lane_ctrl.b2_eq            = s_reg.b2_eq;
		lane_ctrl.b2_swing         = s_reg.b2_swing[lbc_pkg::SWING_LSB +: 3];
		lane_ctrl.b2_short_protect = s_reg.b2_swing[lbc_pkg::SCP_BIT];
		lane_ctrl.b2_terminated    = s_reg.term;
		lane_ctrl.b2_probe         = s_reg.probe;
	end

	assign host_rdata = s_reg.rdata;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// Gap counter restarts with the sequence, so a mode change that
	// restarts probing is not mistaken for a late probe
	logic [23:0] gap_cnt;
	logic        gap_seen;
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n || s_reg.det == lbc_pkg::DET_OFF || mode != s_reg.mode_last)
		begin
			gap_cnt  <= 24'h000000;
			gap_seen <= 1'b0;
		end
		else if (s_reg.probe)
		begin
			gap_cnt  <= 24'h000001;
			gap_seen <= 1'b1;
		end
		else
			gap_cnt <= gap_cnt + 24'h000001;
	end

	a_deemph_reset_value: assert property (
		!$past(reset_n) |-> lane_ctrl.b2_deemph == 3'h2 && lane_ctrl.b1_deemph == 3'h2)
		else $error("De-emphasis reset value wrong");
	a_eq_reset_value: assert property (
		!$past(reset_n) |-> lane_ctrl.b2_eq == 8'h2F && lane_ctrl.b2_swing == 3'h5)
		else $error("Equalization or swing reset wrong");
	a_sd_pin_governs: assert property (
		!global_sd_override && $past(reset_n) && $past(reset_n, 2)
		|-> lane_ctrl.b1_sd_assert == $past(sd_threshold_pin[3:2], 2))
		else $error("Threshold pin not governing");
	a_force_hiz_mode: assert property (
		(global_detect_override && s_reg.b2_det[3:2] == 2'h0) [*2]
		|=> !lane_ctrl.b2_terminated)
		else $error("Mode 00 not high impedance");
	a_force_term_mode: assert property (
		(global_detect_override && s_reg.b2_det[3:2] == 2'h3) [*2]
		|=> lane_ctrl.b2_terminated)
		else $error("Mode 11 not terminated");
	a_probe_only_auto: assert property (
		s_reg.probe |-> s_reg.mode_last == 2'h1 || s_reg.mode_last == 2'h2)
		else $error("Probe outside automatic modes");
	a_probe_spacing: assert property (
		s_reg.probe && gap_seen |-> gap_cnt == 24'(DETECT_PERIOD_CYC))
		else $error("Probe spacing wrong");
	a_attempt_limit: assert property (
		$rose(s_reg.det == lbc_pkg::DET_GIVEUP)
		|-> s_reg.attempts == 6'(DETECT_ATTEMPTS) && mode == 2'h1)
		else $error("Gave up early");
	a_giveup_hiz: assert property (
		s_reg.det == lbc_pkg::DET_GIVEUP |-> !lane_ctrl.b2_terminated)
		else $error("Terminated after giving up");
	a_ever_no_giveup: assert property (
		s_reg.mode_last == 2'h2 && mode == 2'h2 |=> s_reg.det != lbc_pkg::DET_GIVEUP)
		else $error("Mode 10 stopped probing");
	a_hiz_until_found: assert property (
		s_reg.det == lbc_pkg::DET_WAIT && !$past(s_reg.det == lbc_pkg::DET_FOUND)
		|-> !lane_ctrl.b2_terminated)
		else $error("Terminated before detection");
	a_found_terminates: assert property (
		s_reg.probe && mode == s_reg.mode_last
		##1 (s_reg.far_s2 && mode == s_reg.mode_last) [*4] |=> lane_ctrl.b2_terminated)
		else $error("Detection did not terminate");
	a_found_latched: assert property (
		s_reg.det == lbc_pkg::DET_FOUND && mode == s_reg.mode_last
		|=> lane_ctrl.b2_terminated)
		else $error("Detected termination not held");
	a_deemph_write: assert property (
		host_req.wr && !eeprom_req.wr && host_req.addr == 8'h1F
		|=> lane_ctrl.b2_deemph == $past(host_req.data[2:0]))
		else $error("De-emphasis write lost");
	a_eq_write: assert property (
		host_req.wr && !eeprom_req.wr && host_req.addr == 8'h1D
		|=> lane_ctrl.b2_eq == $past(host_req.data))
		else $error("Equalization write lost");
	a_swing_write: assert property (
		host_req.wr && !eeprom_req.wr && host_req.addr == 8'h1E
		|=> lane_ctrl.b2_short_protect == $past(host_req.data[7])
		&& lane_ctrl.b2_swing == $past(host_req.data[2:0]))
		else $error("Swing or protection write lost");
	a_status_readback: assert property (
		host_req.addr == 8'h1F |=> host_rdata[7] == $past(s_reg.term))
		else $error("Detect status bit wrong");
	a_b1_status: assert property (
		host_req.addr == 8'h18 |=> host_rdata[7] == $past(lane_b1_terminated))
		else $error("Lane one status bit wrong");
	a_rsvd_read_zero: assert property (
		host_req.addr == 8'h18 || host_req.addr == 8'h1F |=> host_rdata[6:3] == 4'h0)
		else $error("Reserved status bits not zero");
	a_eeprom_write: assert property (
		eeprom_req.wr && eeprom_req.addr == 8'h1D
		|=> lane_ctrl.b2_eq == $past(eeprom_req.data))
		else $error("EEPROM load lost");

	c_found: cover property (s_reg.det == lbc_pkg::DET_FOUND);
	c_giveup: cover property (s_reg.det == lbc_pkg::DET_GIVEUP);
	c_sd_override: cover property (global_sd_override && host_req.wr
		&& host_req.addr == 8'h19);
	c_eeprom_load: cover property (eeprom_req.wr);
	c_force_term: cover property (lane_ctrl.b2_terminated && s_reg.det == lbc_pkg::DET_OFF);

endmodule

`default_nettype wire

// file: verification/lbc_eeprom_model.sv
// Partner model: configuration loader that writes a short image after power-up
`timescale 1ns/1ps
`default_nettype none

module lbc_eeprom_model (
	// Clock and start
	input  wire logic             sys_clk,
	input  wire logic             start,
	// Load port and completion
	output lbc_pkg::lbc_reg_req_s req,
	output logic                  done
);
	// ==========================================================
	// Image of {offset, data}; reserved bits zero, swing bits 6:3 kept at 0101
	localparam logic [15:0] IMAGE [2] = '{16'h1D15, 16'h1EAE};

	// ==========================================================
	// Loader: one write per cycle, launched at the falling edge like the host
	initial
	begin
		req = '0;
		done = 1'b0;
		@(posedge start);
		foreach (IMAGE[i])
		begin
			@(negedge sys_clk);
			req = '{wr: 1'b1, addr: IMAGE[i][15:8], data: IMAGE[i][7:0]};
		end
		@(negedge sys_clk);
		req.wr = 1'b0;
		// Released bus shows no stale data, so a late sample cannot pass
		req.data = ~req.data;
		done = 1'b1;
	end
endmodule

`default_nettype wire

// file: verification/tb_top.sv
// Testbench: lane B register bank and far-end detect sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// Short detect timing keeps the run small
	localparam int unsigned PER = 40;
	localparam int unsigned ATT = 3;
	// ==========================================================
	// Signals
	logic                    sys_clk;
	logic                    reset_n;
	lbc_pkg::lbc_reg_req_s   host_req;
	logic [7:0]              host_rdata;
	lbc_pkg::lbc_reg_req_s   eeprom_req;
	logic                    sd_ovr;
	logic                    det_ovr;
	logic [3:0]              sd_pin;
	logic [1:0]              det_pin;
	logic                    far_sense;
	logic                    b1_term;
	logic                    ee_start;
	logic                    ee_done;
	lbc_pkg::lbc_lane_ctrl_s lane_ctrl;
	int                      error_cnt;
	int                      num_checks;
	int                      probe_cnt;
	int                      base;

	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (lane_ctrl.b2_probe === 1'b1)
			probe_cnt <= probe_cnt + 1;

	// ==========================================================
	// Design and partner
	lbc_lane_b_config #(.DETECT_PERIOD_CYC(PER), .DETECT_ATTEMPTS(ATT)) u_dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .host_req(host_req),
		.host_rdata(host_rdata), .eeprom_req(eeprom_req),
		.global_sd_override(sd_ovr), .global_detect_override(det_ovr),
		.sd_threshold_pin(sd_pin), .detect_mode_pin(det_pin),
		.far_end_sense(far_sense), .lane_b1_terminated(b1_term), .lane_ctrl(lane_ctrl));
	lbc_eeprom_model u_eeprom (.sys_clk(sys_clk), .start(ee_start), .req(eeprom_req),
		.done(ee_done));

	// ==========================================================
	// Tasks
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		host_req = '{wr: 1'b1, addr: a, data: d};
		@(negedge sys_clk);
		host_req.wr = 1'b0;
	endtask

	// Read data lags the address by one edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(negedge sys_clk);
		host_req.addr = a;
		@(negedge sys_clk);
		check(name, exp, host_rdata);
	endtask

	task automatic wait_term(input logic exp, input int lim);
		int i;
		for (i = 0; i < lim && lane_ctrl.b2_terminated !== exp; i++)
			@(negedge sys_clk);
		check("terminated", {7'h00, exp}, {7'h00, lane_ctrl.b2_terminated});
		if (lane_ctrl.b2_terminated !== exp)
			test_done();
	endtask

	// ==========================================================
	// Sequence
	initial
	begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		host_req = '0;
		{sd_ovr, det_ovr, far_sense, b1_term, ee_start} = '0;
		sd_pin = 4'b0100;
		det_pin = 2'b00;
		{error_cnt, num_checks} = '0;
		repeat (3) @(negedge sys_clk);
		reset_n = 1'b1;
		rd(8'h18, 8'h02, "b1 deemph reset");
		rd(8'h19, 8'h00, "sdth reset");
		rd(8'h1C, 8'h00, "detect reset");
		rd(8'h1D, 8'h2F, "eq reset");
		rd(8'h1E, 8'hAD, "swing reset");
		rd(8'h1F, 8'h02, "b2 deemph reset");
		rd(8'h1A, 8'h00, "reserved reset");
		rd(8'h40, 8'h00, "unmapped");
		$display("Test reset values done");
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h1F, 8'(c));
			check("b2 deemph", 8'(c), {5'h00, lane_ctrl.b2_deemph});
		end
		b1_term = 1'b1;
		wr(8'h18, 8'h05);
		check("b1 deemph", 8'h05, {5'h00, lane_ctrl.b1_deemph});
		rd(8'h18, 8'h85, "b1 status");
		wr(8'h1E, 8'h2E);
		check("protect", 8'h00, {7'h00, lane_ctrl.b2_short_protect});
		check("swing", 8'h06, {5'h00, lane_ctrl.b2_swing});
		wr(8'h1D, 8'h03);
		check("eq", 8'h03, lane_ctrl.b2_eq);
		$display("Test lane fields done");
		wr(8'h19, 8'h0B);
		sd_ovr = 1'b1;
		@(negedge sys_clk);
		check("sd assert", 8'h02, {6'h00, lane_ctrl.b1_sd_assert});
		check("sd deassert", 8'h03, {6'h00, lane_ctrl.b1_sd_deassert});
		sd_ovr = 1'b0;
		@(negedge sys_clk);
		check("sd pin", 8'h04, {4'h0, lane_ctrl.b1_sd_assert, lane_ctrl.b1_sd_deassert});
		$display("Test thresholds done");
		det_ovr = 1'b1;
		wr(8'h1C, 8'h0C);
		wait_term(1'b1, 3);
		wr(8'h1C, 8'h00);
		wait_term(1'b0, 3);
		base = probe_cnt;
		wr(8'h1C, 8'h04);
		repeat (PER * (ATT + 3) - PER / 2) @(negedge sys_clk);
		check("limited probes", 8'(ATT), 8'(probe_cnt - base));
		check("hiz limited", 8'h00, {7'h00, lane_ctrl.b2_terminated});
		base = probe_cnt;
		wr(8'h1C, 8'h08);
		repeat (PER * (ATT + 3) - PER / 2) @(negedge sys_clk);
		check("endless probes", 8'(ATT + 2), 8'(probe_cnt - base));
		check("hiz endless", 8'h00, {7'h00, lane_ctrl.b2_terminated});
		far_sense = 1'b1;
		wait_term(1'b1, PER + 12);
		rd(8'h1F, 8'h87, "b2 status");
		det_ovr = 1'b0;
		wait_term(1'b0, 6);
		det_pin = 2'b11;
		wait_term(1'b1, 6);
		$display("Test detect done");
		ee_start = 1'b1;
		for (int i = 0; i < 10 && ee_done !== 1'b1; i++)
			@(negedge sys_clk);
		check("loader done", 8'h01, {7'h00, ee_done});
		rd(8'h1D, 8'h15, "loaded eq");
		rd(8'h1E, 8'hAE, "loaded swing");
		reset_n = 1'b0;
		@(negedge sys_clk);
		reset_n = 1'b1;
		rd(8'h1D, 8'h2F, "eq second reset");
		$display("Test loader and reset done");
		test_done();
	end
endmodule

`default_nettype wire
